// File: src/rsc_reset_ctrl.sv
`timescale 1ns/1ns
module rsc_reset_ctrl #(
    parameter int RELEASE_N = rsc_pkg::RELEASE_CYCLES
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire rsc_pkg::rsc_axi_req_t axi_req,
    output rsc_pkg::rsc_axi_rsp_t axi_rsp,
    input wire logic ext_reset_n,
    input wire logic stop_mode,
    input wire logic bus_cycle_done,
    input wire logic wdog_timeout,
    input wire logic pll_mode,
    input wire logic pll_locked,
    input wire logic serial_boot_en,
    input wire logic serial_boot_done,
    input wire logic [7:0] bus_addr_data_pins,
    output logic sys_reset_out_n,
    output logic [7:0] cfg_options,
    output logic cfg_valid
);
    import rsc_pkg::*;

    typedef struct packed {
        rsc_state_t state;
        logic [CNT_W-1:0] cnt;
        logic [1:0] pin_cnt;
        logic pin_s1;
        logic pin_s2;
        logic lock_s1;
        logic lock_s2;
        logic [7:0] cfgp_s1;
        logic [7:0] cfgp_s2;
        logic [7:0] pend;
        logic [7:0] cause;
        logic sw_req;
        logic force_out;
        logic out_n;
        logic [7:0] cfg;
        logic cfg_valid;
        logic aw_got;
        logic w_got;
        logic [31:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } rsc_regs_t;

    rsc_regs_t st_r;
    rsc_regs_t st_nxt;
    logic async_hit_r;
    logic stop_pin_hit;
    logic pin_hit;
    logic lock_ok;
    logic [7:0] new_src;
    logic [7:0] src;
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic wr_do;

    ////////////////////////////////////////////////////////////////////////
    // asynchronous stop-mode pin capture
    ////////////////////////////////////////////////////////////////////////

    // clocks are stopped in stop mode, so the pin sets this flop directly
    assign stop_pin_hit = stop_mode & ~ext_reset_n;

    // set wins over the clocked consume, so a held pin is never lost
    always_ff @(posedge mclk or negedge rstn or posedge stop_pin_hit) begin
        if (!rstn) begin
            async_hit_r <= 1'b0;
        end else if (stop_pin_hit) begin
            async_hit_r <= 1'b1;
        end else begin
            async_hit_r <= 1'b0; // state machine takes it on this edge
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source decode
    ////////////////////////////////////////////////////////////////////////

    // fourth consecutive low synchronised sample of the pin
    assign pin_hit = !st_r.pin_s2 && (st_r.pin_cnt == PIN_HOLD_LAST);
    // lock only matters when the pll clock mode is strapped
    assign lock_ok = !pll_mode || st_r.lock_s2;

    // synchronous sources seen this cycle, in cause-flag layout
    always_comb begin
        new_src = 8'h00;
        new_src[SOFT_BIT] = st_r.sw_req;
        new_src[PIN_BIT] = pin_hit;
        new_src[WDOG_BIT] = wdog_timeout;
        new_src[LOL_BIT] = !lock_ok;
        src = st_r.pend | new_src;
    end

    // bus handshake terms
    assign aw_fire = axi_req.awvalid && axi_rsp.awready;
    assign w_fire = axi_req.wvalid && axi_rsp.wready;
    assign ar_fire = axi_req.arvalid && axi_rsp.arready;
    assign wr_do = st_r.aw_got && st_r.w_got && !st_r.bvalid;

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    ////////////////////////////////////////////////////////////////////////

    always_comb begin
        st_nxt = st_r;

        // two-stage synchronisers for pin-side and pll inputs
        st_nxt.pin_s1 = ext_reset_n;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.lock_s1 = pll_locked;
        st_nxt.lock_s2 = st_r.lock_s1;
        st_nxt.cfgp_s1 = bus_addr_data_pins;
        st_nxt.cfgp_s2 = st_r.cfgp_s1;

        // low-sample counter saturates so pin_hit stays as a level
        if (st_r.pin_s2) begin
            st_nxt.pin_cnt = 2'h0;
        end else if (st_r.pin_cnt != PIN_HOLD_LAST) begin
            st_nxt.pin_cnt = st_r.pin_cnt + 2'h1;
        end

        case (st_r.state)
            S_RUN: begin
                if (async_hit_r) begin
                    // stop-mode pin: no wait for the bus cycle
                    st_nxt.cause = src | (8'h01 << PIN_BIT);
                    st_nxt.pend = 8'h00;
                    st_nxt.sw_req = 1'b0;
                    st_nxt.cfg_valid = 1'b0;
                    st_nxt.state = S_WAIT_PIN;
                end else if (src != 8'h00) begin
                    if (bus_cycle_done) begin
                        // bus cycle done: writes in flight are complete
                        st_nxt.cause = src;
                        st_nxt.pend = 8'h00;
                        st_nxt.sw_req = 1'b0;
                        st_nxt.cfg_valid = 1'b0;
                        if (src[PIN_BIT] || src[WDOG_BIT] || src[SOFT_BIT]) begin
                            st_nxt.state = S_WAIT_PIN;
                        end else begin
                            st_nxt.state = S_WAIT_LOCK;
                        end
                    end else begin
                        // deferred: remember short pulses until the bus is free
                        st_nxt.pend = src;
                    end
                end
            end
            S_WAIT_PIN: begin
                // hold while the pin (synchronised or stop-mode) or the watchdog is still asserted; causes stay
                if (st_r.pin_s2 && !wdog_timeout && !async_hit_r) begin
                    st_nxt.state = S_WAIT_LOCK;
                end
            end
            S_WAIT_LOCK: begin
                st_nxt.cnt = '0;
                if (pin_hit || async_hit_r) begin
                    st_nxt.state = S_WAIT_PIN;
                end else if (lock_ok && !wdog_timeout) begin
                    // serial boot replaces the fixed count
                    st_nxt.state = serial_boot_en ? S_BOOT : S_COUNT;
                end
            end
            S_COUNT: begin
                if (pin_hit || async_hit_r) begin
                    st_nxt.state = S_WAIT_PIN;
                end else if (!lock_ok) begin
                    st_nxt.state = S_WAIT_LOCK;
                end else if (st_r.cnt == CNT_W'(RELEASE_N - 1)) begin
                    st_nxt.state = S_SAMPLE;
                end else begin
                    st_nxt.cnt = st_r.cnt + CNT_W'(1);
                end
            end
            S_BOOT: begin
                if (pin_hit || async_hit_r) begin
                    st_nxt.state = S_WAIT_PIN;
                end else if (!lock_ok) begin
                    st_nxt.state = S_WAIT_LOCK;
                end else if (serial_boot_done) begin
                    st_nxt.state = S_RUN;
                end
            end
            S_SAMPLE: begin
                // output is still low here, so straps are being driven
                st_nxt.cfg = st_r.cfgp_s2;
                st_nxt.cfg_valid = 1'b1;
                st_nxt.state = S_RUN;
            end
            default: begin
                st_nxt.state = S_WAIT_LOCK;
            end
        endcase

        // ---- axi4-lite slave: write side
        if (aw_fire) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.awaddr = axi_req.awaddr;
        end
        if (w_fire) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = axi_req.wdata;
            st_nxt.wstrb = axi_req.wstrb;
        end
        if (wr_do) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            if (st_r.awaddr[31:2] == RCR_IDX) begin
                // applied after the entry clear, so a fresh request wins
                if (st_r.wstrb[0]) begin
                    st_nxt.sw_req = st_r.wdata[SW_REQ_BIT];
                    st_nxt.force_out = st_r.wdata[FORCE_OUT_BIT];
                end
            end else if (st_r.awaddr[31:2] != RSR_IDX) begin
                st_nxt.bresp = RESP_SLVERR; // unmapped address; cause register writes get OKAY and are ignored
            end
        end else if (st_r.bvalid && axi_req.bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // ---- axi4-lite slave: read side
        if (ar_fire) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            st_nxt.rdata = 32'h0000_0000;
            if (axi_req.araddr[31:2] == RCR_IDX) begin
                st_nxt.rdata[SW_REQ_BIT] = st_r.sw_req;
                st_nxt.rdata[FORCE_OUT_BIT] = st_r.force_out;
            end else if (axi_req.araddr[31:2] == RSR_IDX) begin
                st_nxt.rdata[7:0] = st_r.cause;
            end else begin
                st_nxt.rresp = RESP_SLVERR;
            end
        end else if (st_r.rvalid && axi_req.rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // output low in every reset state or when software forces it
        st_nxt.out_n = (st_nxt.state == S_RUN) && !st_nxt.force_out;
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    ////////////////////////////////////////////////////////////////////////

    // power-on lands in the lock wait with only the power-on flag set
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.state <= S_WAIT_LOCK;
            st_r.cause <= RSR_POR_VALUE;
            st_r.sw_req <= RCR_RESET[SW_REQ_BIT];
            st_r.force_out <= RCR_RESET[FORCE_OUT_BIT];
            st_r.pin_s1 <= 1'b1;
            st_r.pin_s2 <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    ////////////////////////////////////////////////////////////////////////

    // the async term pulls the pin low even with the clock stopped
    assign sys_reset_out_n = st_r.out_n && !async_hit_r;
    assign cfg_options = st_r.cfg;
    assign cfg_valid = st_r.cfg_valid;

    // one write and one read outstanding; ready drops while answering
    always_comb begin
        axi_rsp.awready = !st_r.aw_got && !st_r.bvalid;
        axi_rsp.wready = !st_r.w_got && !st_r.bvalid;
        axi_rsp.bvalid = st_r.bvalid;
        axi_rsp.bresp = st_r.bresp;
        axi_rsp.arready = !st_r.rvalid;
        axi_rsp.rvalid = st_r.rvalid;
        axi_rsp.rresp = st_r.rresp;
        axi_rsp.rdata = st_r.rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    ////////////////////////////////////////////////////////////////////////

    default clocking chk_cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    chk_out_low_reset: assert property (
        st_r.state != S_RUN |-> !sys_reset_out_n
    ) else $error("reset output high during a reset state");

    chk_pin_six_edges: assert property (
        st_r.state == S_RUN && !stop_mode && bus_cycle_done
        && !st_r.pin_s1 && !st_r.pin_s2 && st_r.pin_cnt == 2'h0
        ##1 !st_r.pin_s2 [*3]
        |=> !sys_reset_out_n
    ) else $error("pin reset not seen within six edges");

    chk_defer_bus: assert property (
        st_r.state == S_RUN && !async_hit_r && !bus_cycle_done
        |=> st_r.state == S_RUN
    ) else $error("synchronous reset taken during a bus cycle");

    chk_count_start: assert property (
        $past(st_r.state) == S_WAIT_LOCK && st_r.state == S_COUNT |-> st_r.cnt == '0
    ) else $error("release count does not start at zero");

    chk_count_end: assert property (
        st_r.state == S_COUNT && st_r.cnt == CNT_W'(RELEASE_N - 1)
        && lock_ok && !pin_hit && !async_hit_r
        |=> st_r.state == S_SAMPLE ##1 st_r.state == S_RUN
    ) else $error("release does not follow the final count");

    chk_lock_relost: assert property (
        (st_r.state == S_COUNT || st_r.state == S_BOOT)
        && !lock_ok && !pin_hit && !async_hit_r
        |=> st_r.state == S_WAIT_LOCK
    ) else $error("lock loss did not return to lock wait");

    chk_pin_restart: assert property (
        (st_r.state == S_WAIT_LOCK || st_r.state == S_COUNT || st_r.state == S_BOOT)
        && pin_hit |=> st_r.state == S_WAIT_PIN
    ) else $error("pin hit did not return to pin wait");

    chk_cause_hold: assert property (
        st_r.state != S_RUN && $past(st_r.state) != S_RUN |-> $stable(st_r.cause)
    ) else $error("cause flags changed inside a reset sequence");

    chk_sw_entry: assert property (
        st_r.state == S_RUN && st_r.sw_req && bus_cycle_done && !wr_do
        |=> st_r.cause[SOFT_BIT] && !st_r.sw_req && st_r.state != S_RUN
    ) else $error("software request not taken and cleared");

    chk_sample_cfg: assert property (
        st_r.state == S_SAMPLE
        |=> cfg_valid && cfg_options == $past(st_r.cfgp_s2) && sys_reset_out_n == !st_r.force_out
    ) else $error("configuration not sampled before release");

    chk_bresp_hold: assert property (
        axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)
    ) else $error("write response dropped before taken");

endmodule // rsc_reset_ctrl

// File: src/rsc_pkg.sv
package rsc_pkg;

    // register indices; byte address is four times the index
    localparam logic [29:0] RCR_IDX = 30'h0;
    localparam logic [29:0] RSR_IDX = 30'h1;

    // reset_ctrl_reg fields and reset value
    localparam int SW_REQ_BIT = 7;
    localparam int FORCE_OUT_BIT = 6;
    localparam logic [7:0] RCR_RESET = 8'h00;

    // reset_cause_reg fields and value after power-on
    localparam int SOFT_BIT = 5;
    localparam int POR_BIT = 3;
    localparam int PIN_BIT = 2;
    localparam int WDOG_BIT = 1;
    localparam int LOL_BIT = 0;
    localparam logic [7:0] RSR_POR_VALUE = 8'h08;

    // sequencing counts, in bus clock cycles
    localparam int RELEASE_CYCLES = 512;
    localparam int CNT_W = 10;
    localparam logic [1:0] PIN_HOLD_LAST = 2'h3; // fourth low sample

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        S_RUN,
        S_WAIT_PIN,
        S_WAIT_LOCK,
        S_COUNT,
        S_BOOT,
        S_SAMPLE
    } rsc_state_t;

    typedef struct packed {
        logic [31:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [31:0] araddr;
        logic arvalid;
        logic rready;
    } rsc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } rsc_axi_rsp_t;

endpackage

// File: sim/rsc_far_model.sv
`timescale 1ns/1ns
// far side: reset pin driver, bus master activity and serial boot engine
module rsc_far_model #(
    parameter int BOOT_N = 20
) (
    input wire logic mclk,
    input wire logic sys_reset_out_n,
    input wire logic serial_boot_en,
    input wire logic pin_go,
    input wire logic [3:0] pin_len,
    input wire logic [3:0] busy_len,
    input wire logic async_low,
    output logic ext_reset_n,
    output logic bus_cycle_done,
    output logic serial_boot_done
);
    logic [3:0] pin_cnt = 4'h0;
    logic [3:0] busy_cnt = 4'h0;
    logic [7:0] boot_cnt = 8'h0;
    ////////////////////////////////////////////////////////////////////////////
    // callers never ask for a pin pulse under four edges
    always_ff @(posedge mclk) begin
        if (pin_go) begin
            pin_cnt <= pin_len;
            busy_cnt <= busy_len;
        end else begin
            pin_cnt <= (pin_cnt != 4'h0) ? pin_cnt - 4'h1 : 4'h0;
            busy_cnt <= (busy_cnt != 4'h0) ? busy_cnt - 4'h1 : 4'h0;
        end
    end
    // pin has a pull-up, so a released pin reads high
    assign ext_reset_n = (pin_cnt == 4'h0) && !async_low;
    assign bus_cycle_done = (busy_cnt == 4'h0);
    ////////////////////////////////////////////////////////////////////////////
    // boot engine only runs while the system is held in reset
    always_ff @(posedge mclk) begin
        if (!sys_reset_out_n && serial_boot_en) begin
            boot_cnt <= (boot_cnt != 8'hFF) ? boot_cnt + 8'h1 : boot_cnt;
        end else begin
            boot_cnt <= 8'h0;
        end
    end
    assign serial_boot_done = (boot_cnt >= 8'(BOOT_N));
endmodule // rsc_far_model

// File: sim/reset_sequence_controller_tb.sv
`timescale 1ns/1ns
module reset_sequence_controller_tb;
    import rsc_pkg::*;
    localparam int REL_N = 8;
    localparam int BOOT_N = 20;
    localparam logic [31:0] CTL_A = {RCR_IDX, 2'b00};
    localparam logic [31:0] CAU_A = {RSR_IDX, 2'b00};
    logic mclk, rstn, ext_reset_n, stop_mode, bus_cycle_done, wdog_timeout, pll_mode;
    logic pll_locked, serial_boot_en, serial_boot_done, sys_reset_out_n, cfg_valid;
    logic pin_go, async_low;
    logic [3:0] pin_len, busy_len;
    logic [7:0] straps, cfg_options;
    logic [31:0] rd;
    logic [1:0] rs;
    rsc_axi_req_t req;
    rsc_axi_rsp_t rsp;
    int seed = 48281;
    int fail_count = 0;
    int n_compared = 0;
    int n, lowc, lim;

    rsc_reset_ctrl #(.RELEASE_N(REL_N)) dut_u (.mclk(mclk), .rstn(rstn), .axi_req(req),
        .axi_rsp(rsp), .ext_reset_n(ext_reset_n), .stop_mode(stop_mode),
        .bus_cycle_done(bus_cycle_done), .wdog_timeout(wdog_timeout), .pll_mode(pll_mode),
        .pll_locked(pll_locked), .serial_boot_en(serial_boot_en),
        .serial_boot_done(serial_boot_done), .bus_addr_data_pins(straps),
        .sys_reset_out_n(sys_reset_out_n), .cfg_options(cfg_options), .cfg_valid(cfg_valid));
    rsc_far_model #(.BOOT_N(BOOT_N)) far_u (.mclk(mclk), .sys_reset_out_n(sys_reset_out_n),
        .serial_boot_en(serial_boot_en), .pin_go(pin_go), .pin_len(pin_len),
        .busy_len(busy_len), .async_low(async_low), .ext_reset_n(ext_reset_n),
        .bus_cycle_done(bus_cycle_done), .serial_boot_done(serial_boot_done));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check_v(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic check_b(input logic got, input string what);
        n_compared++;
        if (got !== 1'b1) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    function automatic logic [31:0] cause(input logic p, s, w, l, o);
        cause = 32'h0;
        cause[POR_BIT] = p;
        cause[PIN_BIT] = s;
        cause[WDOG_BIT] = w;
        cause[LOL_BIT] = l;
        cause[SOFT_BIT] = o;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // register bus: hold each channel until its own handshake edge
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        int k;
        @(posedge mclk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        tb = 1'b0;
        for (k = 0; k < 200 && !tb; k++) begin
            @(negedge mclk);
            ta = req.awvalid && rsp.awready;
            tw = req.wvalid && rsp.wready;
            tb = rsp.bvalid;
            rs = rsp.bresp;
            @(posedge mclk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (tb) req.bready <= 1'b0;
        end
        check_b(tb, "write answer");
    endtask
    task automatic axi_rd(input logic [31:0] a);
        logic ta, tr;
        int k;
        @(posedge mclk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        tr = 1'b0;
        for (k = 0; k < 200 && !tr; k++) begin
            @(negedge mclk);
            ta = req.arvalid && rsp.arready;
            tr = rsp.rvalid;
            rd = rsp.rdata;
            rs = rsp.rresp;
            @(posedge mclk);
            if (ta) req.arvalid <= 1'b0;
            if (tr) req.rready <= 1'b0;
        end
        check_b(tr, "read answer");
    endtask
    // edges until output asserts, then cycles held low
    task automatic wait_low();
        n = 0;
        @(negedge mclk);
        while (sys_reset_out_n !== 1'b0 && n < 60) begin
            @(negedge mclk);
            n++;
        end
        // a wait that runs out is a mismatch of its own
        if (n >= 60) begin
            fail_count++;
            $display("wrong value at %0t: reset output never asserted", $time);
        end
    endtask
    task automatic wait_rel();
        lowc = 0;
        while (sys_reset_out_n !== 1'b1 && lowc < 3000) begin
            @(negedge mclk);
            lowc++;
        end
        if (lowc >= 3000) begin
            fail_count++;
            $display("wrong value at %0t: reset output never released", $time);
        end
    endtask
    task automatic rd_cause(input logic [31:0] exp);
        axi_rd(CAU_A);
        check_v(rd, exp, "cause");
    endtask
    task automatic done(input string name);
        $display("test %s ended: %0d compared, %0d wrong", name, n_compared, fail_count);
    endtask
    task automatic close_out();
        $display("compared %0d, wrong %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // a hung handshake or sequence ends here
    initial begin
        repeat (30000) @(posedge mclk);
        fail_count++;
        close_out();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        req = '0;
        {stop_mode, wdog_timeout, serial_boot_en, pin_go, async_low} = 5'h00;
        {pll_mode, pll_locked} = 2'h3;
        {pin_len, busy_len} = 8'h40;
        straps = 8'h5A;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        wait_rel();
        check_b(lowc >= REL_N && lowc <= REL_N + 8, "power-up release");
        check_v(32'(cfg_options), 32'(straps), "straps");
        check_b(cfg_valid, "straps valid");
        rd_cause(32'(RSR_POR_VALUE));
        axi_rd(CTL_A);
        check_v(rd, 32'(RCR_RESET), "control reset");
        axi_rd(32'h0000_0008);
        check_v(rd, 32'h0, "unmapped data");
        check_v(32'(rs), 32'(RESP_SLVERR), "unmapped read");
        axi_wr(32'h0000_0008, 32'h0);
        check_v(32'(rs), 32'(RESP_SLVERR), "unmapped write");
        axi_wr(CAU_A, 32'h0000_00FF);
        check_v(32'(rs), 32'(RESP_OKAY), "cause write");
        rd_cause(32'(RSR_POR_VALUE));
        done("power-up");
        // pin requests with random pulse length and bus occupancy
        repeat (4) begin
            @(posedge mclk);
            straps <= 8'($random(seed));
            pin_len <= 4'(4 + $unsigned($random(seed)) % 6);
            busy_len <= 4'($unsigned($random(seed)) % 9);
            pin_go <= 1'b1;
            // one-cycle strobe; the far model drives the pin at this edge
            @(posedge mclk);
            pin_go <= 1'b0;
            wait_low();
            lim = (busy_len > 4'h5) ? int'(busy_len) + 1 : 6;
            check_b(n >= 4 && n <= lim, "pin to output");
            @(posedge mclk);
            wdog_timeout <= 1'b1;
            @(posedge mclk);
            wdog_timeout <= 1'b0;
            wait_rel();
            check_b(lowc >= REL_N, "pin hold");
            check_v(32'(cfg_options), 32'(straps), "straps");
            rd_cause(cause(0, 1, 0, 0, 0));
        end
        done("pin");
        @(posedge mclk);
        wdog_timeout <= 1'b1;
        @(posedge mclk);
        wdog_timeout <= 1'b0;
        wait_low();
        check_v(n, 0, "watchdog entry");
        wait_rel();
        rd_cause(cause(0, 0, 1, 0, 0));
        done("watchdog");
        axi_wr(CTL_A, 32'h0000_0080);
        wait_low();
        check_b(n <= 1, "software entry");
        wait_rel();
        axi_rd(CTL_A);
        check_v(rd, 32'h0, "request cleared");
        rd_cause(cause(0, 0, 0, 0, 1));
        done("software");
        // force bit pulls the output low without starting a sequence
        axi_wr(CTL_A, 32'h0000_0040);
        @(negedge mclk);
        check_b(!sys_reset_out_n, "forced low");
        axi_rd(CTL_A);
        check_v(rd, 32'h0000_0040, "force bit");
        axi_wr(CTL_A, 32'h0000_0000);
        @(negedge mclk);
        check_b(sys_reset_out_n, "force released");
        rd_cause(cause(0, 0, 0, 0, 1));
        done("force");
        @(posedge mclk);
        pll_locked <= 1'b0;
        wait_low();
        check_b(n <= 4, "lock loss entry");
        repeat (30) @(posedge mclk);
        check_b(!sys_reset_out_n, "held while unlocked");
        pll_locked <= 1'b1;
        wait_rel();
        check_b(lowc >= REL_N, "relock hold");
        rd_cause(cause(0, 0, 0, 1, 0));
        done("lock");
        @(posedge mclk);
        serial_boot_en <= 1'b1;
        wdog_timeout <= 1'b1;
        @(posedge mclk);
        wdog_timeout <= 1'b0;
        wait_low();
        wait_rel();
        check_b(lowc >= BOOT_N && !cfg_valid, "boot hold");
        serial_boot_en <= 1'b0;
        done("boot");
        // pin asserted mid-cycle in stop mode, no edge between
        @(posedge mclk);
        stop_mode <= 1'b1;
        @(posedge mclk);
        #30 async_low = 1'b1;
        #5 check_b(!sys_reset_out_n, "stop-mode pin");
        @(posedge mclk);
        async_low <= 1'b0;
        stop_mode <= 1'b0;
        wait_rel();
        rd_cause(cause(0, 1, 0, 0, 0));
        done("stop");
        @(posedge mclk);
        wdog_timeout <= 1'b1;
        wait_low();
        @(posedge mclk);
        rstn <= 1'b0;
        @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        wdog_timeout <= 1'b0;
        wait_rel();
        check_b(lowc >= REL_N, "restart hold");
        rd_cause(32'(RSR_POR_VALUE));
        done("restart");
        close_out();
    end
endmodule // reset_sequence_controller_tb
